// >>> include/src_pkg.sv
// Constants, layouts and carriers for the slot reservation conflict manager
// Operation
// - Conflict needs shared slot and matching antennas
// - Two foreign period reservations never conflict
// - Own foreign keeps; own Type B keeps unless neighbour foreign
// - Neighbour foreign or Type B: stop, Conflict
// - Own zero, neighbour one: stay zero, stop
// - Own one, neighbour zero: may keep
// - Equal status: tie-breaker and slot decide winner
// - Both zero, losing: never raise status
// - Both one, losing: stop, clear status (equal slot numbers: no stop, status stays one)
// - Conflict reason adds availability element
// - Withdrawal starts backoff at minimum window
// - Failed negotiation doubles window, saturating
// - Redraw per negotiation, leave after idle
// - Realign reassert only equivalent, not larger
// - Realign avoids periods, status-one slots preferably
// - Merged elements report Modified until echoed
// - Owner slot removal keeps status, Modified
// - Follow target removal within two superframes
// - Targets follow owner change within two superframes
// - Owner follows target termination within two superframes
// - Missed beacons beyond limit drop element
// - Retransmit after gap, only if time fits
package src_pkg;
  localparam int          AW          = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_OWN     = 8'h04;
  localparam logic [7:0]  OFS_NBR     = 8'h08;
  localparam logic [7:0]  OFS_OWN_SL  = 8'h0C;
  localparam logic [7:0]  OFS_NBR_SL  = 8'h10;
  localparam logic [7:0]  OFS_BP_SL   = 8'h14;
  localparam logic [7:0]  OFS_S1_SL   = 8'h18;
  localparam logic [7:0]  OFS_OLD     = 8'h1C;
  localparam logic [7:0]  OFS_KEY     = 8'h20;
  localparam logic [7:0]  OFS_BO_CFG  = 8'h24;
  localparam logic [7:0]  OFS_MISS    = 8'h28;
  localparam logic [7:0]  OFS_TXN     = 8'h2C;
  localparam logic [7:0]  OFS_RESULT  = 8'h30;
  localparam logic [7:0]  OFS_BACKOFF = 8'h34;
  localparam logic [7:0]  OFS_ALLOWED = 8'h38;
  // CTRL bits: levels 0..3, write-only pulses 4..12
  localparam int C_OWN_B = 0;
  localparam int C_NBR_B = 1;
  localparam int C_TGT   = 2;
  localparam int C_ACT   = 3;
  localparam int C_EVAL  = 4;
  localparam int C_DONE  = 5;
  localparam int C_FAIL  = 6;
  localparam int C_REQ   = 7;
  localparam int C_MOD   = 8;
  localparam int C_ECHO  = 9;
  localparam int C_CHG   = 10;
  localparam int C_FDONE = 11;
  localparam int C_HEARD = 12;
  // Reason codes
  localparam logic [2:0] RC_ACCEPTED = 3'h0;
  localparam logic [2:0] RC_CONFLICT = 3'h1;
  localparam logic [2:0] RC_PENDING  = 3'h2;
  localparam logic [2:0] RC_DENIED   = 3'h3;
  localparam logic [2:0] RC_MODIFIED = 3'h4;
  // Reset values
  localparam logic [7:0]  BO_MIN_RST   = 8'h02;
  localparam logic [7:0]  BO_MAX_RST   = 8'h10;
  localparam logic [7:0]  MISS_RST     = 8'h03;
  localparam logic [15:0] LFSR_SEED    = 16'hACE1;
  localparam logic [1:0]  FOLLOW_SF    = 2'h2;
  localparam logic [1:0]  BO_IDLE_MULT = 2'h2;
  // Timing
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         SIFS_NS       = 2500;
  localparam logic [7:0] SIFS_CYC      = 8'((SIFS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Reservation element as written by software
  typedef struct packed {
    logic [3:0] bcn_ant;
    logic [7:0] slot_no;
    logic [3:0] ant;
    logic       rsvd;
    logic       foreign;
    logic       tiebreak;
    logic       status;
  } src_elem_s;
  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [31:0]   writedata;
  } src_av_req_s;
endpackage

// >>> rtl/src_conflict_mgr.sv
// Conflict resolution, backoff, upkeep and retransmit gating of reservations
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
module src_conflict_mgr #(
  parameter int SLOT_W = 32
) (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  // Avalon-MM slave
  input  wire src_pkg::src_av_req_s av_in,
  output logic [31:0]              av_readdata_out,
  output logic                     av_waitrequest_out,
  // Superframe and retransmit timing, same clock
  input  wire logic                sf_tick_in,
  input  wire logic                ack_end_in,
  input  wire logic [15:0]         block_remain_in,
  // Beacon and transmit control
  output logic                     tx_stop_out,
  output logic                     avail_elem_out,
  output logic                     status_out,
  output logic [2:0]               reason_out,
  output logic                     req_blocked_out,
  output logic                     elem_drop_out,
  output logic                     retx_ok_out
);
  import src_pkg::*;

  typedef struct packed {
    logic              wait_q;
    logic [31:0]       rdata;
    logic [3:0]        ctrl;
    src_elem_s         own;
    src_elem_s         nbr;
    logic [SLOT_W-1:0] own_sl;
    logic [SLOT_W-1:0] nbr_sl;
    logic [SLOT_W-1:0] bp_sl;
    logic [SLOT_W-1:0] s1_sl;
    logic [23:0]       old_rec;
    logic [15:0]       key;
    logic [7:0]        bo_min;
    logic [7:0]        bo_max;
    logic [7:0]        bo_win;
    logic [7:0]        bo_cnt;
    logic [9:0]        bo_idle;
    logic              bo_act;
    logic [15:0]       lfsr;
    logic [7:0]        max_miss;
    logic [7:0]        miss;
    logic              mod_pend;
    logic              fol_pend;
    logic [1:0]        fol_cnt;
    logic              dropped;
    logic [15:0]       txn_len;
    logic [7:0]        gap;
    logic              gap_arm;
    logic              conflict;
    logic              keep;
    logic              stop;
    logic              stat;
    logic [2:0]        reason;
    logic [3:0]        rule;
    logic              avail;
    logic              retx_ok;
    logic              blocked;
  } src_state_s;

  src_state_s r_r;
  src_state_s r_nxt;

  function automatic logic [7:0] draw(input logic [15:0] rnd, input logic [7:0] w);
    logic [23:0] p;
    // Widen before multiplying, or the high product bits are lost
    p = 24'(rnd) * 24'(w);
    return p[23:16];
  endfunction

  function automatic logic [7:0] dbl(input logic [7:0] w, input logic [7:0] mx);
    logic [8:0] d;
    d = {w, 1'b0};
    return (d > {1'b0, mx}) ? mx : d[7:0];
  endfunction

  function automatic logic [7:0] popcnt(input logic [SLOT_W-1:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < SLOT_W; i++) begin
      c = c + 8'(v[i]);
    end
    return c;
  endfunction

  logic              acc;
  logic              wr;
  logic [31:0]       wd;
  logic              shared;
  logic              tb_eq;
  logic              win;
  logic              tgt;
  logic              realign_ok;
  logic [SLOT_W-1:0] cand;
  logic [SLOT_W-1:0] pref;
  logic [SLOT_W-1:0] allowed;
  logic [31:0]       res_word;
  logic [31:0]       bo_word;
  logic              drop_evt;

  always_comb begin
    r_nxt = r_r;
    acc   = (av_in.read | av_in.write) & ~r_r.wait_q;
    wr    = acc & av_in.write;
    wd    = av_in.writedata;
    tgt   = r_r.ctrl[C_TGT];
    drop_evt = 1'b0;

    // Bus handshake: one wait cycle, then one cycle with waitrequest low
    r_nxt.wait_q = ~((av_in.read | av_in.write) & r_r.wait_q);

    // Conflict detection
    shared = |(r_r.own_sl & r_r.nbr_sl) && (r_r.nbr.ant == r_r.nbr.bcn_ant)
             && (r_r.nbr.ant == r_r.own.ant);
    if (r_r.own.foreign && r_r.nbr.foreign) begin
      shared = 1'b0;
    end
    tb_eq = (r_r.own.tiebreak == r_r.nbr.tiebreak);
    win   = (tb_eq && (r_r.own.slot_no < r_r.nbr.slot_no)) ||
            (!tb_eq && (r_r.own.slot_no > r_r.nbr.slot_no));

    // Priority chain, first match only
    r_nxt.conflict = shared;
    r_nxt.keep     = 1'b1;
    r_nxt.stop     = 1'b0;
    r_nxt.stat     = r_r.own.status;
    r_nxt.rule     = 4'h0;
    r_nxt.reason   = r_r.mod_pend ? RC_MODIFIED : RC_ACCEPTED;
    if (shared) begin
      if (r_r.own.foreign) begin
        r_nxt.rule = 4'h1;
      end else if (r_r.nbr.foreign) begin
        r_nxt.rule = 4'h2;
        r_nxt.keep = 1'b0;
        r_nxt.stop = 1'b1;
      end else if (r_r.ctrl[C_OWN_B]) begin
        r_nxt.rule = 4'h3;
      end else if (r_r.ctrl[C_NBR_B]) begin
        r_nxt.rule = 4'h4;
        r_nxt.keep = 1'b0;
        r_nxt.stop = 1'b1;
      end else if (!r_r.own.status && r_r.nbr.status) begin
        r_nxt.rule = 4'h5;
        r_nxt.keep = 1'b0;
        r_nxt.stop = 1'b1;
        r_nxt.stat = 1'b0;
      end else if (r_r.own.status && !r_r.nbr.status) begin
        r_nxt.rule = 4'h6;
      end else if (win) begin
        r_nxt.rule = 4'h7;
      end else if (!r_r.own.status) begin
        r_nxt.rule = 4'h8;
        r_nxt.keep = 1'b0;
        r_nxt.stat = 1'b0;
      end else if (r_r.own.slot_no != r_r.nbr.slot_no) begin
        // Losing with status one: we clear status rather than trim slots
        r_nxt.rule = 4'h9;
        r_nxt.keep = 1'b0;
        r_nxt.stop = 1'b1;
        r_nxt.stat = 1'b0;
      end
      if (tgt && !r_nxt.keep) begin
        r_nxt.reason = RC_CONFLICT;
      end
    end
    if (r_r.dropped) begin
      r_nxt.stat = 1'b0;
    end
    r_nxt.avail = (r_nxt.reason == RC_CONFLICT);

    // Realignment limits
    realign_ok = (r_r.key == r_r.old_rec[15:0]) &&
                 (popcnt(r_r.own_sl) <= r_r.old_rec[23:16]);
    cand    = r_r.own_sl & ~r_r.bp_sl;
    pref    = cand & ~r_r.s1_sl;
    allowed = (|pref) ? pref : cand;

    // Random source advances every cycle
    r_nxt.lfsr = {r_r.lfsr[14:0],
                  r_r.lfsr[15] ^ r_r.lfsr[13] ^ r_r.lfsr[12] ^ r_r.lfsr[10]};

    // Backoff
    if (sf_tick_in && r_r.bo_act) begin
      if (r_r.bo_cnt != 8'h00) begin
        r_nxt.bo_cnt = r_r.bo_cnt - 8'h01;
      end
      // Idle time runs from the last request, count or not
      if (r_r.bo_idle >= (10'(r_r.bo_win) << BO_IDLE_MULT)) begin
        r_nxt.bo_act = 1'b0;
      end else begin
        r_nxt.bo_idle = r_r.bo_idle + 10'h001;
      end
    end
    if (wr && av_in.address == OFS_CTRL) begin
      if (wd[C_REQ]) begin
        r_nxt.bo_idle = 10'h000;
      end
      if (wd[C_DONE] && r_r.bo_act) begin
        r_nxt.bo_cnt = draw(r_r.lfsr, r_r.bo_win);
      end
      if (wd[C_FAIL] && r_r.bo_act) begin
        r_nxt.bo_win = dbl(r_r.bo_win, r_r.bo_max);
        r_nxt.bo_cnt = draw(r_r.lfsr, dbl(r_r.bo_win, r_r.bo_max));
      end
      if (wd[C_EVAL] && shared && r_r.stop && !tgt) begin
        r_nxt.bo_act  = 1'b1;
        r_nxt.bo_win  = r_r.bo_min;
        r_nxt.bo_cnt  = draw(r_r.lfsr, r_r.bo_min);
        r_nxt.bo_idle = 10'h000;
      end
    end

    r_nxt.blocked = r_nxt.bo_act && (r_nxt.bo_cnt != 8'h00);

    // Lost partner and follow-up deadlines
    if (sf_tick_in && r_r.ctrl[C_ACT]) begin
      if (r_r.miss != 8'hFF) begin
        r_nxt.miss = r_r.miss + 8'h01;
      end
      if (r_r.miss >= r_r.max_miss) begin
        drop_evt = 1'b1;
      end
    end
    if (sf_tick_in && r_r.fol_pend) begin
      r_nxt.fol_cnt = r_r.fol_cnt + 2'h1;
      if (r_r.fol_cnt + 2'h1 >= FOLLOW_SF) begin
        // Software missed the window: drop rather than keep stale slots
        drop_evt       = 1'b1;
        r_nxt.fol_pend = 1'b0;
      end
    end

    // Register writes
    if (wr) begin
      case (av_in.address)
        OFS_CTRL: begin
          r_nxt.ctrl = wd[3:0];
          if (wd[C_ACT]) begin
            r_nxt.dropped = 1'b0;
          end
          if (wd[C_HEARD] || wd[C_ACT]) begin
            r_nxt.miss = 8'h00;
          end
          if (wd[C_ECHO]) begin
            r_nxt.mod_pend = 1'b0;
          end
          if (wd[C_MOD]) begin
            r_nxt.mod_pend = 1'b1;
          end
          if (wd[C_FDONE]) begin
            r_nxt.fol_pend = 1'b0;
          end
          if (wd[C_CHG]) begin
            r_nxt.fol_pend = 1'b1;
            r_nxt.fol_cnt  = 2'h0;
          end
        end
        OFS_OWN:    r_nxt.own = src_elem_s'(wd[19:0]);
        OFS_NBR:    r_nxt.nbr = src_elem_s'(wd[19:0]);
        OFS_OWN_SL: r_nxt.own_sl = wd[SLOT_W-1:0];
        OFS_NBR_SL: r_nxt.nbr_sl = wd[SLOT_W-1:0];
        OFS_BP_SL:  r_nxt.bp_sl = wd[SLOT_W-1:0];
        OFS_S1_SL:  r_nxt.s1_sl = wd[SLOT_W-1:0];
        OFS_OLD:    r_nxt.old_rec = wd[23:0];
        OFS_KEY:    r_nxt.key = wd[15:0];
        OFS_BO_CFG: begin
          r_nxt.bo_min = wd[7:0];
          r_nxt.bo_max = wd[15:8];
        end
        OFS_MISS:   r_nxt.max_miss = wd[7:0];
        OFS_TXN:    r_nxt.txn_len = wd[15:0];
        default: ;
      endcase
    end
    // Drop beats a re-arm written in the same cycle
    if (drop_evt) begin
      r_nxt.dropped     = 1'b1;
      r_nxt.ctrl[C_ACT] = 1'b0;
    end

    // Retransmit gating
    if (ack_end_in) begin
      r_nxt.gap     = SIFS_CYC;
      r_nxt.gap_arm = 1'b1;
    end else if (r_r.gap != 8'h00) begin
      r_nxt.gap = r_r.gap - 8'h01;
    end
    r_nxt.retx_ok = r_r.gap_arm && (r_r.gap == 8'h00) && !ack_end_in
                    && (block_remain_in >= r_r.txn_len);

    // Read mux
    res_word = {15'h0000, r_r.dropped, r_r.fol_pend, r_r.mod_pend, realign_ok,
                r_r.avail, r_r.rule, 1'b0, r_r.reason, r_r.stat, r_r.stop,
                r_r.keep, r_r.conflict};
    bo_word  = {r_r.bo_idle[7:0], r_r.bo_cnt, r_r.bo_win, 6'h00,
                r_r.blocked, r_r.bo_act};
    r_nxt.rdata = 32'h0000_0000;
    // Launched with the falling waitrequest, so both stand together
    if (av_in.read && r_r.wait_q) begin
      case (av_in.address)
        OFS_CTRL:    r_nxt.rdata = {28'h0000000, r_r.ctrl};
        OFS_OWN:     r_nxt.rdata = {12'h000, r_r.own};
        OFS_NBR:     r_nxt.rdata = {12'h000, r_r.nbr};
        OFS_OWN_SL:  r_nxt.rdata = 32'(r_r.own_sl);
        OFS_NBR_SL:  r_nxt.rdata = 32'(r_r.nbr_sl);
        OFS_BP_SL:   r_nxt.rdata = 32'(r_r.bp_sl);
        OFS_S1_SL:   r_nxt.rdata = 32'(r_r.s1_sl);
        OFS_OLD:     r_nxt.rdata = {8'h00, r_r.old_rec};
        OFS_KEY:     r_nxt.rdata = {16'h0000, r_r.key};
        OFS_BO_CFG:  r_nxt.rdata = {16'h0000, r_r.bo_max, r_r.bo_min};
        OFS_MISS:    r_nxt.rdata = {16'h0000, r_r.miss, r_r.max_miss};
        OFS_TXN:     r_nxt.rdata = {16'h0000, r_r.txn_len};
        OFS_RESULT:  r_nxt.rdata = res_word;
        OFS_BACKOFF: r_nxt.rdata = bo_word;
        OFS_ALLOWED: r_nxt.rdata = 32'(allowed);
        default:     r_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      r_r          <= '0;
      r_r.wait_q   <= 1'b1;
      r_r.bo_min   <= BO_MIN_RST;
      r_r.bo_max   <= BO_MAX_RST;
      r_r.bo_win   <= BO_MIN_RST;
      r_r.max_miss <= MISS_RST;
      r_r.lfsr     <= LFSR_SEED;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign av_readdata_out    = r_r.rdata;
  assign av_waitrequest_out = r_r.wait_q;
  assign tx_stop_out        = r_r.stop;
  assign avail_elem_out     = r_r.avail;
  assign status_out         = r_r.stat;
  assign reason_out         = r_r.reason;
  assign req_blocked_out    = r_r.blocked;
  assign elem_drop_out      = r_r.dropped;
  assign retx_ok_out        = r_r.retx_ok;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence both_foreign_s;
    r_r.own.foreign && r_r.nbr.foreign;
  endsequence

  conflict_gate_a: assert property (r_r.conflict
                                    |-> $past(r_r.nbr.ant) == $past(r_r.own.ant))
    else $error("conflict flagged with unequal antennas");
  foreign_pair_a: assert property (both_foreign_s ##1 both_foreign_s |-> !r_r.conflict)
    else $error("foreign pair flagged as conflict");
  own_keep_a: assert property ((r_r.rule == 4'h1 || r_r.rule == 4'h3) |-> r_r.keep)
    else $error("own priority reservation not kept");
  nbr_stop_a: assert property ((r_r.rule == 4'h2 || r_r.rule == 4'h4) && $past(tgt)
                                |-> r_r.stop && r_r.reason == RC_CONFLICT)
    else $error("yield to neighbour missing");
  zero_hold_a: assert property (r_r.rule == 4'h5 || r_r.rule == 4'h8 |-> !r_r.stat)
    else $error("status raised while losing");
  win_keep_a: assert property (r_r.rule inside {4'h6, 4'h7} |-> r_r.keep && !r_r.stop)
    else $error("winner did not keep");
  one_lose_a: assert property (r_r.rule == 4'h9 |-> r_r.stop && !r_r.stat)
    else $error("status-one loser kept transmitting");
  avail_tie_a: assert property (r_r.avail == (r_r.reason == RC_CONFLICT))
    else $error("availability element mismatch");
  win_bound_a: assert property (r_r.bo_act
                                |-> r_r.bo_cnt < r_r.bo_win || r_r.bo_win == 8'h00)
    else $error("backoff count out of window");
  win_sat_a: assert property ($rose(r_r.bo_win > r_r.bo_max) |-> $changed(r_r.bo_max))
    else $error("backoff window beyond maximum");
  sifs_wait_a: assert property (ack_end_in |=> !r_r.retx_ok [*8])
    else $error("retransmit allowed inside gap");
  miss_drop_a: assert property (sf_tick_in && r_r.ctrl[C_ACT] && r_r.miss >= r_r.max_miss
                                |=> r_r.dropped ##1 !r_r.stat)
    else $error("lost partner not dropped");
endmodule

// >>> bench/src_far_model.sv
// Far-side timing model: superframe starts, acknowledgement ends, block time
module src_far_model (
  // Clock
  input  wire logic        clk_in,
  // Towards the manager
  output logic             sf_tick_out,
  output logic             ack_end_out,
  output logic [15:0]      block_remain_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sf_tick_out = 1'b0;
    ack_end_out = 1'b0;
    block_remain_out = 16'h0000;
  end

  // Superframes shortened to a few cycles, only their count matters here
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in);
      sf_tick_out <= 1'b1;
      @(posedge clk_in);
      sf_tick_out <= 1'b0;
      repeat (6) @(posedge clk_in);
    end
  endtask

  task automatic ack();
    @(posedge clk_in);
    ack_end_out <= 1'b1;
    @(posedge clk_in);
    ack_end_out <= 1'b0;
  endtask

  task automatic set_remain(input logic [15:0] v);
    @(posedge clk_in);
    block_remain_out <= v;
  endtask
endmodule

// >>> bench/src_conflict_mgr_bench.sv
// Self-checking bench for the reservation conflict manager
module src_conflict_mgr_bench;
  import src_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] NC  = {4'b0000, RC_ACCEPTED};
  localparam logic [6:0] K0  = {4'b1000, RC_ACCEPTED};
  localparam logic [6:0] K1  = {4'b1001, RC_ACCEPTED};
  localparam logic [6:0] LC  = {4'b1110, RC_CONFLICT};
  localparam logic [6:0] ALL = 7'h7F;
  localparam logic [6:0] NS  = 7'h5F;

  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  src_av_req_s av = '0;
  logic [31:0] rdata;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        sf_tick;
  logic        ack_end;
  logic [15:0] remain;
  logic        tx_stop;
  logic        avail;
  logic        status;
  logic [2:0]  reason;
  logic        blocked;
  logic        drop;
  logic        retx_ok;
  logic [7:0]  w;
  int          n;
  int          err_count = 0;
  int          checked = 0;

  always #20 clk_in = ~clk_in;

  src_conflict_mgr dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .av_in(av),
    .av_readdata_out(av_rdata), .av_waitrequest_out(av_wait),
    .sf_tick_in(sf_tick), .ack_end_in(ack_end), .block_remain_in(remain),
    .tx_stop_out(tx_stop), .avail_elem_out(avail), .status_out(status),
    .reason_out(reason), .req_blocked_out(blocked), .elem_drop_out(drop),
    .retx_ok_out(retx_ok)
  );

  src_far_model far (
    .clk_in(clk_in), .sf_tick_out(sf_tick), .ack_end_out(ack_end),
    .block_remain_out(remain)
  );

  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checked++;
    if ((got & msk) !== (exp & msk)) begin
      err_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    av <= {rd, ~rd, a, d};
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (av_wait !== 1'b0 && k < 20);
    rdata = av_rdata;
    av <= '0;
    if (av_wait !== 1'b0) begin
      err_count++;
      $display("BAD t=%0t bus access never answered", $time);
      end_of_test();
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  function automatic logic [31:0] el(input logic [2:0] f, input logic [7:0] sl,
                                     input logic [3:0] an);
    return {12'h000, an, sl, an, 1'b0, f};
  endfunction

  // Flag order: conflict, stop, availability, status, reason
  task automatic run(input logic [3:0] c, input logic [31:0] o, input logic [31:0] nb,
                     input logic [6:0] e, input logic [6:0] m);
    bus(1'b0, OFS_OWN, o);
    bus(1'b0, OFS_NBR, nb);
    bus(1'b0, OFS_CTRL, {28'h0000000, c});
    settle();
    bus(1'b1, OFS_RESULT, 32'h00000000);
    chk({25'h0, rdata[0], tx_stop, avail, status, reason}, {25'h0, e}, {25'h0, m});
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    bus(1'b1, OFS_BO_CFG, 32'h0);
    chk(rdata, 32'h00001002, 32'h0000FFFF);
    bus(1'b1, OFS_MISS, 32'h0);
    chk(rdata, 32'h00000003, 32'h0000FFFF);
    bus(1'b0, 8'h3C, 32'hFFFFFFFF);
    bus(1'b1, 8'h3C, 32'h0);
    chk(rdata, 32'h00000000, 32'hFFFFFFFF);
    bus(1'b0, OFS_OWN_SL, 32'h00000001);
    bus(1'b0, OFS_NBR_SL, 32'h00000001);
    run(4'hC, el(3'h0, 8'h05, 4'h1), el(3'h1, 8'h03, 4'h2), NC, ALL);
    run(4'hC, el(3'h5, 8'h05, 4'h1), el(3'h5, 8'h03, 4'h1), NC | 7'h08, ALL);
    run(4'hC, el(3'h4, 8'h05, 4'h1), el(3'h1, 8'h03, 4'h1), K0, ALL);
    run(4'hD, el(3'h0, 8'h05, 4'h1), el(3'h1, 8'h03, 4'h1), K0, ALL);
    run(4'hC, el(3'h0, 8'h05, 4'h1), el(3'h4, 8'h03, 4'h1), LC, ALL);
    run(4'hE, el(3'h0, 8'h05, 4'h1), el(3'h0, 8'h03, 4'h1), LC, ALL);
    run(4'hC, el(3'h0, 8'h05, 4'h1), el(3'h1, 8'h03, 4'h1), LC, ALL);
    run(4'hC, el(3'h1, 8'h05, 4'h1), el(3'h0, 8'h03, 4'h1), K1, ALL);
    run(4'hC, el(3'h0, 8'h03, 4'h1), el(3'h0, 8'h05, 4'h1), K0, ALL);
    run(4'hC, el(3'h2, 8'h07, 4'h1), el(3'h0, 8'h05, 4'h1), K0, ALL);
    run(4'hC, el(3'h0, 8'h07, 4'h1), el(3'h0, 8'h05, 4'h1), LC, NS);
    run(4'hC, el(3'h2, 8'h03, 4'h1), el(3'h0, 8'h05, 4'h1), LC, NS);
    run(4'hC, el(3'h1, 8'h07, 4'h1), el(3'h1, 8'h05, 4'h1), LC, ALL);
    run(4'hC, el(3'h3, 8'h03, 4'h1), el(3'h1, 8'h05, 4'h1), LC, ALL);
    run(4'h8, el(3'h0, 8'h05, 4'h1), el(3'h1, 8'h03, 4'h1), K0 | 7'h20, 7'h78);
    // Owner withdraws after losing, then negotiations keep failing
    bus(1'b0, OFS_CTRL, 32'h00000018);
    bus(1'b1, OFS_BACKOFF, 32'h0);
    chk(rdata, 32'h00000201, 32'h0000FF01);
    chk({25'h0, rdata[23:17]}, 32'h0, 32'h7F);
    w = 8'h02;
    for (int i = 0; i < 4; i++) begin
      w = (w == BO_MAX_RST) ? w : {w[6:0], 1'b0};
      bus(1'b0, OFS_CTRL, 32'h00000048);
      bus(1'b1, OFS_BACKOFF, 32'h0);
      chk(rdata, {16'h0000, w, 8'h00}, 32'h0000FF00);
      chk({31'h0, blocked}, {31'h0, rdata[1]}, 32'h1);
    end
    // Silent partner: drop only after more than the limit, then follow-up deadline drop and its cancel
    bus(1'b0, OFS_CTRL, 32'h00000008);
    far.tick(3);
    bus(1'b1, OFS_MISS, 32'h0);
    chk(rdata, 32'h00000303, 32'h0000FFFF);
    chk({31'h0, drop}, 32'h0, 32'h1);
    far.tick(1);
    settle();
    chk({31'h0, drop}, 32'h1, 32'h1);
    bus(1'b0, OFS_CTRL, 32'h00000408);
    far.tick(1);
    settle();
    chk({31'h0, drop}, 32'h0, 32'h1);
    far.tick(1);
    settle();
    chk({31'h0, drop}, 32'h1, 32'h1);
    bus(1'b0, OFS_CTRL, 32'h00000408);
    far.tick(1);
    bus(1'b0, OFS_CTRL, 32'h00000808);
    far.tick(2);
    settle();
    chk({31'h0, drop}, 32'h0, 32'h1);
    // Backoff stays through four windows of silence, then ends
    bus(1'b0, OFS_CTRL, 32'h00000088);
    far.tick(64);
    bus(1'b1, OFS_BACKOFF, 32'h0);
    chk(rdata, 32'h40001001, 32'hFFFFFF03);
    chk({31'h0, blocked}, 32'h0, 32'h1);
    far.tick(1);
    bus(1'b1, OFS_BACKOFF, 32'h0);
    chk(rdata, 32'h00000000, 32'h00000001);
    // Modified reason until the target echoes
    bus(1'b0, OFS_CTRL, 32'h00000108);
    settle();
    chk({29'h0, reason}, {29'h0, RC_MODIFIED}, 32'h7);
    bus(1'b0, OFS_CTRL, 32'h00000208);
    settle();
    chk({29'h0, reason}, {29'h0, RC_ACCEPTED}, 32'h7);
    // Realignment: equivalence, then slot preferences
    bus(1'b0, OFS_KEY, 32'h00001234);
    bus(1'b0, OFS_OLD, 32'h00011234);
    bus(1'b1, OFS_RESULT, 32'h0);
    chk(rdata, 32'h00002000, 32'h00002000);
    bus(1'b0, OFS_OLD, 32'h00001234);
    bus(1'b1, OFS_RESULT, 32'h0);
    chk(rdata, 32'h00000000, 32'h00002000);
    bus(1'b0, OFS_OWN_SL, 32'h0000000F);
    bus(1'b0, OFS_BP_SL, 32'h00000001);
    bus(1'b0, OFS_S1_SL, 32'h00000002);
    bus(1'b1, OFS_ALLOWED, 32'h0);
    chk(rdata, 32'h0000000C, 32'hFFFFFFFF);
    bus(1'b0, OFS_S1_SL, 32'h0000000E);
    bus(1'b1, OFS_ALLOWED, 32'h0);
    chk(rdata, 32'h0000000E, 32'hFFFFFFFF);
    // Retransmit gap, then a block too short for the transaction
    bus(1'b0, OFS_TXN, 32'h0000000A);
    far.set_remain(16'h0064);
    far.ack();
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (retx_ok !== 1'b1 && n < 200);
    chk({31'h0, n > SIFS_CYC && n < SIFS_CYC + 12}, 32'h1, 32'h1);
    far.set_remain(16'h0005);
    settle();
    chk({31'h0, retx_ok}, 32'h0, 32'h1);
    end_of_test();
  end

  initial begin
    repeat (50000) @(posedge clk_in);
    err_count++;
    $display("BAD t=%0t run limit reached", $time);
    end_of_test();
  end
endmodule
